// >>> hdl/cpu_status_pkg.sv
/*
 * constants for the status / option / interrupt-control register group:
 * register addresses, bit positions, reset values and the flag-unit ops.
 * assumes an 8-bit file address whose top bit is the direct bank bit.
 */
package cpu_status_pkg;

    // register file addresses
    localparam logic [7:0] STATUS_ADDR    = 8'h03;
    localparam logic [7:0] OPTION_ADDR    = 8'h81;
    localparam logic [7:0] INTCTL_ADDR    = 8'h0b;
    localparam logic [6:0] MIRROR_MASK    = 7'h7f;

    // status bit positions
    localparam int IND_BANK_BIT  = 7;
    localparam int DIR_HI_BIT    = 6;
    localparam int DIR_LO_BIT    = 5;
    localparam int TIMEOUT_BIT   = 4;
    localparam int PWRDOWN_BIT   = 3;
    localparam int ZERO_BIT      = 2;
    localparam int DCARRY_BIT    = 1;
    localparam int CARRY_BIT     = 0;

    // option bit positions
    localparam int PULLUP_DIS_BIT = 7;
    localparam int INT_EDGE_BIT   = 6;
    localparam int TMR_SRC_BIT    = 5;
    localparam int TMR_EDGE_BIT   = 4;
    localparam int PRESC_SEL_BIT  = 3;
    localparam int PS_MSB         = 2;

    // interrupt control bit positions
    localparam int GLOBAL_EN_BIT = 7;
    localparam int TMR_IE_BIT    = 5;
    localparam int EXT_IE_BIT    = 4;
    localparam int PORT_IE_BIT   = 3;
    localparam int TMR_IF_BIT    = 2;
    localparam int EXT_IF_BIT    = 1;
    localparam int PORT_IF_BIT   = 0;

    // reset values and write masks
    localparam logic [7:0] STATUS_RST   = 8'h18;
    localparam logic [7:0] OPTION_RST   = 8'hff;
    localparam logic [7:0] INTCTL_RST   = 8'h00;
    localparam logic [7:0] INTCTL_WMASK = 8'hbf;
    localparam logic [7:0] STATUS_WMASK = 8'he7;

    // each data bank spans 128 bytes
    localparam int BANK_OFFSET_W = 7;

    typedef enum logic [2:0] {
        OP_ADD  = 3'b000,
        OP_SUB  = 3'b001,
        OP_AND  = 3'b010,
        OP_IOR  = 3'b011,
        OP_XOR  = 3'b100,
        OP_RLF  = 3'b101,
        OP_RRF  = 3'b110,
        OP_PASS = 3'b111
    } alu_op_t;

endpackage

// >>> hdl/alu_flag_unit.sv
/*
 * combinational flag evaluation for one datapath operation: zero,
 * digit carry and carry, plus a mask of the flags the operation touches.
 * assumes operands are stable for the cycle in which they are flagged.
 */
`timescale 1ns/1ps
`default_nettype none
module alu_flag_unit
    import cpu_status_pkg::*;
(
    input  wire logic [7:0] op_a,
    input  wire logic [7:0] op_b,
    input  wire alu_op_t    op,
    input  wire logic       carry_in,
    output logic            zero,
    output logic            digit_carry,
    output logic            carry,
    output logic [2:0]      flag_mask
);

    function automatic logic [8:0] add9(input logic [7:0] x,
                                        input logic [7:0] y,
                                        input logic       cin);
        add9 = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    endfunction

    logic [8:0] sum;
    logic [8:0] nib;
    logic [7:0] result;

    always_comb begin
        sum         = 9'h000;
        nib         = 9'h000;
        result      = 8'h00;
        carry       = carry_in;
        digit_carry = 1'b0;
        flag_mask   = 3'b100;
        unique case (op)
            OP_ADD: begin
                sum = add9(op_a, op_b, 1'b0);
                nib = add9({4'h0, op_a[3:0]}, {4'h0, op_b[3:0]}, 1'b0);
                flag_mask = 3'b111;
            end
            // two's complement add, so carry reads as not-borrow; see RULE9
            OP_SUB: begin
                sum = add9(op_a, ~op_b, 1'b1);
                nib = add9({4'h0, op_a[3:0]}, {4'h0, ~op_b[3:0]}, 1'b1);
                flag_mask = 3'b111;
            end
            OP_AND:  sum = {1'b0, op_a & op_b};
            OP_IOR:  sum = {1'b0, op_a | op_b};
            OP_XOR:  sum = {1'b0, op_a ^ op_b};
            // rotates touch only carry; see RULE10
            OP_RLF: begin
                sum = {op_a[7], op_a[6:0], carry_in};
                flag_mask = 3'b001;
            end
            OP_RRF: begin
                sum = {op_a[0], carry_in, op_a[7:1]};
                flag_mask = 3'b001;
            end
            OP_PASS: sum = {1'b0, op_a};
        endcase
        result      = sum[7:0];
        digit_carry = nib[4];                     // see RULE7
        if (flag_mask[0]) begin
            carry = sum[8];                       // see RULE8
        end
    end

    assign zero = (result == 8'h00);              // see RULE6

endmodule
`default_nettype wire

// >>> hdl/cpu_status_option_regs.sv
/*
 * status, option and interrupt-control registers of the core, with bank
 * address forming, pull-up, prescaler, edge and timer-source decode.
 * assumes the datapath drives all strobes synchronously to mclk.
 */
// Functional notes
// RULE1 - two direct bank bits pick one of four 128-byte data banks
// RULE2 - software keeps upper direct and indirect bank bits at zero
// RULE3 - indirect bank bit picks banks 2-3 when set, 0-1 when clear
// RULE4 - timeout flag set by power-up, watchdog clear, sleep; timeout clears
// RULE5 - power-down flag set by power-up, watchdog clear; cleared by sleep
// RULE6 - zero flag follows whether the operation result is zero
// RULE7 - digit carry is carry out of bit 3, inverted sense for borrow
// RULE8 - carry is carry out of bit 7, inverted sense for borrow
// RULE9 - subtract adds two's complement, so carry means no borrow
// RULE10 - rotates load carry with the bit shifted out
// RULE11 - option register fully readable and writable
// RULE12 - pull-up disable set kills all pull-ups, else per-pin latch
// RULE13 - prescaler given to watchdog leaves the timer at 1:1
// RULE14 - prescale field gives timer 1:2..1:256 or watchdog 1:1..1:128
// RULE15 - interrupt flags set regardless of their enables
// RULE16 - flag-affecting op writing status keeps its own flag results
// RULE17 - global enable passes unmasked interrupts, else blocks all
// RULE18 - edge select picks rising (1) or falling (0) external edge
// RULE19 - timer source picks pin or cycle tick; edge bit picks falling
`timescale 1ns/1ps
`default_nettype none
module cpu_status_option_regs
    import cpu_status_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     wr_en,
    input  wire logic [7:0]               wr_addr,
    input  wire logic [7:0]               wr_data,
    input  wire logic [7:0]               rd_addr,
    output logic [7:0]                    rd_data,
    input  wire logic                     alu_valid,
    input  wire alu_op_t                  alu_op,
    input  wire logic [7:0]               alu_a,
    input  wire logic [7:0]               alu_b,
    input  wire logic                     watchdog_clear_instr,
    input  wire logic                     sleep_instr,
    input  wire logic                     watchdog_timeout,
    input  wire logic [BANK_OFFSET_W-1:0] dir_offset,
    output logic [8:0]                    direct_addr,
    input  wire logic [7:0]               fsr,
    output logic [8:0]                    indirect_addr,
    input  wire logic [7:0]               port_b_latch,
    output logic [7:0]                    port_b_pullup_en,
    input  wire logic                     ext_interrupt_pin,
    input  wire logic                     port_b_change,
    input  wire logic                     timer_overflow,
    output logic                          interrupt_request,
    input  wire logic                     timer_ext_clock_pin,
    input  wire logic                     instr_cycle_tick,
    output logic                          timer_count_tick,
    output logic [3:0]                    timer_ratio_log2,
    output logic [2:0]                    watchdog_ratio_log2
);

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] option;
        logic [7:0] intctl;
        logic [7:0] rd_data;
        logic       ext_pin_d;
        logic       tmr_pin_d;
    } state_t;

    localparam state_t STATE_RST = '{STATUS_RST, OPTION_RST, INTCTL_RST,
                                     8'h00, 1'b0, 1'b0};

    state_t s;
    state_t next_s;

    logic       fu_zero;
    logic       fu_dcarry;
    logic       fu_carry;
    logic [2:0] fu_mask;
    logic       ext_edge;
    logic       tmr_edge;

    // status and interrupt control are mirrored in both banks
    function automatic logic hits(input logic [7:0] a,
                                  input logic [7:0] reg_addr);
        hits = (a[6:0] & MIRROR_MASK) == reg_addr[6:0];
    endfunction

    alu_flag_unit flags (
        .op_a        (alu_a),
        .op_b        (alu_b),
        .op          (alu_op),
        .carry_in    (s.status[CARRY_BIT]),
        .zero        (fu_zero),
        .digit_carry (fu_dcarry),
        .carry       (fu_carry),
        .flag_mask   (fu_mask)
    );

    // pin edge selection uses the registered previous sample
    assign ext_edge = s.option[INT_EDGE_BIT]                 // see RULE18
                    ? (ext_interrupt_pin & ~s.ext_pin_d)
                    : (~ext_interrupt_pin & s.ext_pin_d);
    assign tmr_edge = s.option[TMR_EDGE_BIT]
                    ? (~timer_ext_clock_pin & s.tmr_pin_d)
                    : (timer_ext_clock_pin & ~s.tmr_pin_d);

    always_comb begin
        next_s = s;
        next_s.ext_pin_d = ext_interrupt_pin;
        next_s.tmr_pin_d = timer_ext_clock_pin;

        // read path: mirrored status/intctl, option only at its own address
        if (hits(rd_addr, STATUS_ADDR)) begin
            next_s.rd_data = s.status;
        end else if (hits(rd_addr, INTCTL_ADDR)) begin
            next_s.rd_data = s.intctl;
        end else if (rd_addr == OPTION_ADDR) begin
            next_s.rd_data = s.option;                    // see RULE11
        end else begin
            next_s.rd_data = 8'h00;
        end

        if (wr_en && wr_addr == OPTION_ADDR) begin
            next_s.option = wr_data;                      // see RULE11
        end

        // timeout and power-down bits are never written by software
        if (wr_en && hits(wr_addr, STATUS_ADDR)) begin
            next_s.status = (s.status & ~STATUS_WMASK)
                          | (wr_data & STATUS_WMASK);
        end

        // operation flags override an explicit status write; see RULE16
        if (alu_valid) begin
            if (fu_mask[2]) next_s.status[ZERO_BIT]   = fu_zero;
            if (fu_mask[1]) next_s.status[DCARRY_BIT] = fu_dcarry;
            if (fu_mask[0]) next_s.status[CARRY_BIT]  = fu_carry;
        end

        // a timeout in the same cycle as clear/sleep wins; see RULE4
        if (watchdog_timeout) begin
            next_s.status[TIMEOUT_BIT] = 1'b0;
        end else if (watchdog_clear_instr || sleep_instr) begin
            next_s.status[TIMEOUT_BIT] = 1'b1;
        end
        if (sleep_instr) begin                            // see RULE5
            next_s.status[PWRDOWN_BIT] = 1'b0;
        end else if (watchdog_clear_instr) begin
            next_s.status[PWRDOWN_BIT] = 1'b1;
        end

        if (wr_en && hits(wr_addr, INTCTL_ADDR)) begin
            next_s.intctl = wr_data & INTCTL_WMASK;
        end
        // set after the write so an event never loses to a clear
        if (timer_overflow) next_s.intctl[TMR_IF_BIT]  = 1'b1; // see RULE15
        if (ext_edge)       next_s.intctl[EXT_IF_BIT]  = 1'b1; // see RULE15
        if (port_b_change)  next_s.intctl[PORT_IF_BIT] = 1'b1; // see RULE15
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data = s.rd_data;

    // reserved bank bits are honoured as stored; software keeps them 0
    assign direct_addr = {s.status[DIR_HI_BIT],           // see RULE1
                          s.status[DIR_LO_BIT], dir_offset};
    assign indirect_addr = {s.status[IND_BANK_BIT], fsr}; // see RULE3

    assign port_b_pullup_en = s.option[PULLUP_DIS_BIT]    // see RULE12
                            ? 8'h00 : port_b_latch;

    // watchdog gets the field as is, timer one step more; see RULE14
    assign timer_ratio_log2 = s.option[PRESC_SEL_BIT]     // see RULE13
                            ? 4'h0
                            : {1'b0, s.option[PS_MSB:0]} + 4'h1;
    assign watchdog_ratio_log2 = s.option[PRESC_SEL_BIT]
                               ? s.option[PS_MSB:0] : 3'h0;

    assign timer_count_tick = s.option[TMR_SRC_BIT]       // see RULE19
                            ? tmr_edge : instr_cycle_tick;

    assign interrupt_request = s.intctl[GLOBAL_EN_BIT]    // see RULE17
        & |(s.intctl[TMR_IE_BIT:PORT_IE_BIT] & s.intctl[TMR_IF_BIT:0]);

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic [4:0] nib_sum;
    assign nib_sum = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};

    direct_bank_a: assert property (                           // RULE1
        wr_en && hits(wr_addr, STATUS_ADDR)
        |=> direct_addr == {$past(wr_data[DIR_HI_BIT:DIR_LO_BIT]), dir_offset})
        else $error("direct bank address wrong");
    indirect_bank_a: assert property (                         // RULE3
        wr_en && hits(wr_addr, STATUS_ADDR)
        |=> indirect_addr == {$past(wr_data[IND_BANK_BIT]), fsr})
        else $error("indirect bank address wrong");
    timeout_clear_a: assert property (                         // RULE4
        watchdog_timeout |=> !s.status[TIMEOUT_BIT])
        else $error("timeout flag not cleared");
    sleep_flags_a: assert property (                           // RULE5
        sleep_instr && !watchdog_timeout
        |=> !s.status[PWRDOWN_BIT] && s.status[TIMEOUT_BIT])
        else $error("sleep flag update wrong");
    zero_flag_a: assert property (                             // RULE6
        alu_valid && alu_op == OP_AND
        |=> s.status[ZERO_BIT] == ($past(alu_a & alu_b) == 8'h00))
        else $error("zero flag wrong");
    digit_carry_a: assert property (                           // RULE7
        alu_valid && alu_op == OP_ADD
        |=> s.status[DCARRY_BIT] == $past(nib_sum[4]))
        else $error("digit carry wrong");
    sub_borrow_a: assert property (                            // RULE9
        alu_valid && alu_op == OP_SUB
        |=> s.status[CARRY_BIT] == ($past(alu_a) >= $past(alu_b)))
        else $error("subtract carry not inverted borrow");
    rotate_carry_a: assert property (                          // RULE10
        alu_valid && alu_op == OP_RLF
        |=> s.status[CARRY_BIT] == $past(alu_a[7]))
        else $error("rotate carry wrong");
    option_write_a: assert property (                          // RULE11
        wr_en && wr_addr == OPTION_ADDR && rd_addr == OPTION_ADDR
        ##1 rd_addr == OPTION_ADDR |=> rd_data == $past(wr_data, 2))
        else $error("option readback wrong");
    pullup_off_a: assert property (                            // RULE12
        wr_en && wr_addr == OPTION_ADDR && wr_data[PULLUP_DIS_BIT]
        |=> port_b_pullup_en == 8'h00)
        else $error("pull-ups not disabled");
    timer_bypass_a: assert property (                          // RULE13
        wr_en && wr_addr == OPTION_ADDR && wr_data[PRESC_SEL_BIT]
        |=> timer_ratio_log2 == 4'h0)
        else $error("timer not 1:1");
    flag_set_a: assert property (                              // RULE15
        port_b_change |=> s.intctl[PORT_IF_BIT])
        else $error("flag lost");
    flag_priority_a: assert property (                         // RULE16
        alu_valid && alu_op == OP_AND && wr_en
        && hits(wr_addr, STATUS_ADDR)
        |=> s.status[ZERO_BIT] == ($past(alu_a & alu_b) == 8'h00))
        else $error("status write beat flag result");
    global_block_a: assert property (                          // RULE17
        wr_en && hits(wr_addr, INTCTL_ADDR) && !wr_data[GLOBAL_EN_BIT]
        |=> !interrupt_request)
        else $error("interrupt leaked past global enable");

    sleep_c: cover property (sleep_instr ##1 watchdog_timeout);
    int_c: cover property (ext_edge ##[1:20] interrupt_request);
    sub_c: cover property (alu_valid && alu_op == OP_SUB ##1
                           !s.status[CARRY_BIT]);

endmodule
`default_nettype wire

// >>> bench/cpu_datapath_model.sv
/*
 * behavioural cpu datapath: register writes and reads, flag operations
 * and reset-status events, each launched from a task on a falling edge.
 * assumes the register block samples every strobe on the rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_datapath_model
    import cpu_status_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic [7:0] rd_data,
    output logic            wr_en,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic [7:0]      rd_addr,
    output logic            alu_valid,
    output alu_op_t         alu_op,
    output logic [7:0]      alu_a,
    output logic [7:0]      alu_b,
    output logic            watchdog_clear_instr,
    output logic            sleep_instr,
    output logic            watchdog_timeout
);
    // set only by the bank-decode scenario, which breaks the habit on purpose
    logic allow_rsvd;

    initial begin
        {wr_en, alu_valid, allow_rsvd} = 3'b000;
        {wr_addr, wr_data, rd_addr, alu_a, alu_b} = 40'h0;
        alu_op = OP_PASS;
        {watchdog_clear_instr, sleep_instr, watchdog_timeout} = 3'b000;
    end

    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        if (a[6:0] == STATUS_ADDR[6:0] && !allow_rsvd) begin
            wr_data = d & 8'h3f;
        end
        @(negedge mclk);
        wr_en = 1'b0;
        // released data bus shows junk, not the last value
        wr_data = ~wr_data;
    endtask

    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        rd_addr = a;
        @(negedge mclk);
        d = rd_data;
    endtask

    task automatic op(input alu_op_t o, input logic [7:0] a,
                      input logic [7:0] b, input logic wr);
        @(negedge mclk);
        alu_valid = 1'b1;
        alu_op = o;
        alu_a = a;
        alu_b = b;
        wr_en = wr;
        wr_addr = STATUS_ADDR;
        wr_data = 8'h00;
        @(negedge mclk);
        alu_valid = 1'b0;
        wr_en = 1'b0;
    endtask

    task automatic pulse(input int k);
        @(negedge mclk);
        watchdog_clear_instr = (k == 0);
        sleep_instr = (k == 1);
        watchdog_timeout = (k == 2);
        @(negedge mclk);
        {watchdog_clear_instr, sleep_instr, watchdog_timeout} = 3'b000;
    endtask
endmodule
`default_nettype wire

// >>> bench/tb_cpu_status_option_regs.sv
/*
 * self-checking bench for the status / option / interrupt-control block.
 * assumes the datapath model drives the bus; pins are driven here.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_status_option_regs
    import cpu_status_pkg::*;
;
    logic       mclk, rst, wr_en, alu_valid, watchdog_clear_instr;
    logic       sleep_instr, watchdog_timeout, port_b_change, timer_overflow;
    logic       ext_interrupt_pin, timer_ext_clock_pin, instr_cycle_tick;
    logic       interrupt_request, timer_count_tick;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data, alu_a, alu_b, fsr, v;
    logic [7:0] port_b_latch, port_b_pullup_en;
    logic [6:0] dir_offset;
    logic [8:0] direct_addr, indirect_addr;
    logic [3:0] timer_ratio_log2;
    logic [2:0] watchdog_ratio_log2, f;
    alu_op_t    alu_op;
    int         err_total, comparisons;
    alu_op_t    ops[16] = '{OP_ADD, OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_SUB,
                            OP_AND, OP_IOR, OP_XOR, OP_XOR, OP_RLF, OP_RLF,
                            OP_RRF, OP_RRF, OP_PASS, OP_PASS};
    logic [7:0] aa[16] = '{8'h0f, 8'hff, 8'h00, 8'h03, 8'h05, 8'h10, 8'h0f,
                           8'h00, 8'h5a, 8'h5a, 8'h80, 8'h01, 8'h01, 8'h02,
                           8'h00, 8'h07};
    logic [7:0] bb[16] = '{8'h01, 8'h01, 8'h00, 8'h05, 8'h05, 8'h01, 8'hf0,
                           8'h00, 8'h5a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h00, 8'h00};

    cpu_status_option_regs u_cpu_status_option_regs (
        .mclk, .rst, .wr_en, .wr_addr, .wr_data, .rd_addr, .rd_data,
        .alu_valid, .alu_op, .alu_a, .alu_b, .watchdog_clear_instr,
        .sleep_instr, .watchdog_timeout, .dir_offset, .direct_addr, .fsr,
        .indirect_addr, .port_b_latch, .port_b_pullup_en,
        .ext_interrupt_pin, .port_b_change, .timer_overflow,
        .interrupt_request, .timer_ext_clock_pin, .instr_cycle_tick,
        .timer_count_tick, .timer_ratio_log2, .watchdog_ratio_log2
    );

    cpu_datapath_model u_cpu_datapath_model (
        .mclk, .rd_data, .wr_en, .wr_addr, .wr_data, .rd_addr, .alu_valid,
        .alu_op, .alu_a, .alu_b, .watchdog_clear_instr, .sleep_instr,
        .watchdog_timeout
    );

    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_cpu_datapath_model.write(a, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        u_cpu_datapath_model.read(a, v);
        chk(v, e);
    endtask

    task automatic strobe(input int k);
        @(negedge mclk);
        {timer_overflow, port_b_change} = (k == 0) ? 2'b10 : 2'b01;
        @(negedge mclk);
        {timer_overflow, port_b_change} = 2'b00;
    endtask

    // flags expected after an op that starts from all three set
    function automatic logic [2:0] expect_flags(input alu_op_t o,
                                                input logic [7:0] a,
                                                input logic [7:0] b);
        logic [7:0] x;
        logic [8:0] s;
        logic [4:0] n;
        logic [2:0] r;
        r = 3'b111;
        x = (o == OP_SUB) ? ~b : b;
        s = {1'b0, a} + {1'b0, x} + {8'h00, o == OP_SUB};
        n = {1'b0, a[3:0]} + {1'b0, x[3:0]} + {4'h0, o == OP_SUB};
        case (o)
            OP_ADD, OP_SUB: r = {s[7:0] == 8'h00, n[4], s[8]};
            OP_AND: r[2] = (a & b) == 8'h00;
            OP_IOR: r[2] = (a | b) == 8'h00;
            OP_XOR: r[2] = (a ^ b) == 8'h00;
            OP_RLF: r[0] = a[7];
            OP_RRF: r[0] = a[0];
            default: r[2] = a == 8'h00;
        endcase
        return r;
    endfunction

    initial begin
        #40000;
        err_total++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        {port_b_change, timer_overflow, ext_interrupt_pin} = 3'b000;
        {timer_ext_clock_pin, instr_cycle_tick} = 2'b00;
        dir_offset = 7'h55;
        fsr = 8'ha5;
        port_b_latch = 8'h3c;
        err_total = 0;
        comparisons = 0;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        rc(STATUS_ADDR, 8'h18);
        rc(OPTION_ADDR, 8'hff);
        rc(INTCTL_ADDR, 8'h00);
        rc(8'h04, 8'h00);
        for (int i = 0; i < 16; i++) begin
            wr(STATUS_ADDR, 8'h07);
            u_cpu_datapath_model.op(ops[i], aa[i], bb[i], 1'b0);
            f = expect_flags(ops[i], aa[i], bb[i]);
            rc(STATUS_ADDR, {5'h03, f});
        end
        // flag-affecting op and a status write in the same cycle
        wr(STATUS_ADDR, 8'h07);
        u_cpu_datapath_model.op(OP_ADD, 8'hff, 8'h01, 1'b1);
        rc(STATUS_ADDR, 8'h1f);
        wr(STATUS_ADDR, 8'h07);
        u_cpu_datapath_model.op(OP_AND, 8'h0f, 8'h0f, 1'b1);
        rc(STATUS_ADDR, 8'h18);
        u_cpu_datapath_model.allow_rsvd = 1'b1;
        for (int i = 0; i < 4; i++) begin
            v = {i[0], i[1:0], 5'h00};
            wr(STATUS_ADDR, v);
            chk(direct_addr, {v[6:5], 7'h55});
            chk(indirect_addr, {v[7], 8'ha5});
        end
        u_cpu_datapath_model.allow_rsvd = 1'b0;
        wr(STATUS_ADDR, 8'h00);
        u_cpu_datapath_model.pulse(1);
        rc(STATUS_ADDR, 8'h10);
        u_cpu_datapath_model.pulse(2);
        rc(STATUS_ADDR, 8'h00);
        u_cpu_datapath_model.pulse(1);
        rc(STATUS_ADDR, 8'h10);
        u_cpu_datapath_model.pulse(0);
        rc(STATUS_ADDR, 8'h18);
        for (int i = 0; i < 16; i++) begin
            v = {i[0], 3'b000, i[3:0]};
            wr(OPTION_ADDR, v);
            rc(OPTION_ADDR, v);
            chk(port_b_pullup_en, v[7] ? 8'h00 : 8'h3c);
            f = v[3] ? 3'h0 : v[2:0] + 3'h1;
            chk(timer_ratio_log2, v[3] ? 4'h0 : 4'h1 + v[2:0]);
            chk(watchdog_ratio_log2, v[3] ? v[2:0] : 3'h0);
        end
        wr(INTCTL_ADDR, 8'h00);
        strobe(0);
        rc(INTCTL_ADDR, 8'h04);
        chk(interrupt_request, 1'b0);
        wr(INTCTL_ADDR, 8'ha4);
        chk(interrupt_request, 1'b1);
        wr(INTCTL_ADDR, 8'h24);
        chk(interrupt_request, 1'b0);
        wr(OPTION_ADDR, 8'h40);
        wr(INTCTL_ADDR, 8'h00);
        @(negedge mclk) ext_interrupt_pin = 1'b1;
        // slack for the pin sampling stage ahead of the flag
        repeat (3) @(negedge mclk);
        rc(INTCTL_ADDR, 8'h02);
        wr(OPTION_ADDR, 8'h00);
        wr(INTCTL_ADDR, 8'h00);
        @(negedge mclk) ext_interrupt_pin = 1'b0;
        repeat (3) @(negedge mclk);
        rc(INTCTL_ADDR, 8'h02);
        wr(INTCTL_ADDR, 8'h00);
        @(negedge mclk) ext_interrupt_pin = 1'b1;
        repeat (3) @(negedge mclk);
        strobe(1);
        rc(INTCTL_ADDR, 8'h01);
        @(negedge mclk) instr_cycle_tick = 1'b1;
        #1 chk(timer_count_tick, 1'b1);
        @(negedge mclk) instr_cycle_tick = 1'b0;
        #1 chk(timer_count_tick, 1'b0);
        wr(OPTION_ADDR, 8'h20);
        @(negedge mclk) timer_ext_clock_pin = 1'b1;
        #1 chk(timer_count_tick, 1'b1);
        @(negedge mclk);
        #1 chk(timer_count_tick, 1'b0);
        wr(OPTION_ADDR, 8'h30);
        @(negedge mclk) timer_ext_clock_pin = 1'b0;
        #1 chk(timer_count_tick, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
